// ===== verif/dhrap_props.sv
// Checker of the wire rules on the interface between the two register port ends.
`timescale 1ns/1ps
module dhrap_props (
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic host_shared_bus_dev_oe,
  input wire logic host_write_strobe_n,
  input wire logic host_read_strobe_n,
  input wire logic chip_sel_n
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);
  // ------------------------------------------------------------------
  // Serial frame tracker
  // ------------------------------------------------------------------
  logic       scl_q;
  logic       sda_q;
  logic       in_frame;
  logic [3:0] bit_cnt;
  logic [3:0] rel_cnt;
  logic [1:0] byte_idx;
  logic [7:0] shreg;
  logic [7:0] first_byte;
  logic       scl_rise;
  logic       start;
  logic       stop;
  logic       dev_low;
  // Edges seen at the system clock; the line is slow enough to sample.
  assign scl_rise = scl & ~scl_q;
  assign start    = scl & scl_q & sda_q & ~sda;
  assign stop     = scl & scl_q & ~sda_q & sda;
  assign dev_low  = sda_dev_oe & ~sda_dev_o;
  // The ninth rising clock of each byte is the acknowledge slot.
  always_ff @(posedge SYS_CLK_I) begin
    scl_q <= scl;
    sda_q <= sda;
    if (!NRST_I) begin
      in_frame <= 1'b0;
      bit_cnt  <= 4'h0;
      byte_idx <= 2'h0;
    end else if (start) begin
      in_frame <= 1'b1;
      bit_cnt  <= 4'h0;
      byte_idx <= 2'h0;
    end else if (stop) begin
      in_frame <= 1'b0;
    end else if (scl_rise && in_frame) begin
      if (bit_cnt != 4'h8) begin
        shreg   <= {shreg[6:0], sda};
        bit_cnt <= bit_cnt + 4'h1;
      end else begin
        bit_cnt <= 4'h0;
        if (byte_idx == 2'h0) first_byte <= shreg;
        if (byte_idx != 2'h3) byte_idx <= byte_idx + 2'h1;
      end
    end
  end
  // Cycles since a selected read was last active, saturating at 15.
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I || (!chip_sel_n && !host_read_strobe_n)) rel_cnt <= 4'h0;
    else if (rel_cnt != 4'hF) rel_cnt <= rel_cnt + 4'h1;
  end
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_bus_release_late: assert property (host_shared_bus_dev_oe |-> rel_cnt <= 4'h4)
    else $error("shared bus still driven after the selected read ended");
  a_read_drives_bus: assert property ((!host_read_strobe_n && !chip_sel_n) [*5]
    |-> host_shared_bus_dev_oe)
    else $error("shared bus not driven during a selected read");
  a_write_no_drive: assert property ((!host_write_strobe_n && host_read_strobe_n) [*5]
    |-> !host_shared_bus_dev_oe)
    else $error("shared bus driven by the device during a write");
  a_reset_quiet_lines: assert property ($rose(NRST_I) |-> !host_shared_bus_dev_oe && !dev_low)
    else $error("device drives a line straight after reset");
  a_ack_slave_addr: assert property (scl_rise && in_frame && bit_cnt == 4'h8 && byte_idx == 2'h0
    && shreg[7:1] == 7'h1F |-> !sda)
    else $error("slave address byte not acknowledged");
  a_ack_write_bytes: assert property (scl_rise && in_frame && bit_cnt == 4'h8
    && byte_idx inside {2'h1, 2'h2} && first_byte == 8'h3E |-> !sda)
    else $error("register or data byte not acknowledged");
  a_sda_in_frame: assert property (dev_low |-> in_frame)
    else $error("device pulls the data line outside a frame");
  a_sda_scl_low: assert property ($changed(dev_low) |-> !scl)
    else $error("device changed the data line while the clock was high");
endmodule

// ===== verif/testbench.sv
// Self-checking bench: host end against device end, plus a hand-driven second device.
`timescale 1ns/1ps
module testbench;
  logic                  sys_clk;
  logic                  nrst;
  logic                  req;
  dhrap_pkg::dhrap_cmd_t cmd;
  logic [7:0]            addr;
  logic [7:0]            data;
  logic                  busy;
  logic                  done;
  logic [7:0]            rdata;
  logic                  wr_stb;
  logic [5:0]            wr_addr;
  logic [7:0]            wr_data;
  logic [5:0]            rd_addr;
  logic [7:0]            regs [64];
  logic [7:0]            wr_cnt;
  logic [7:0]            last_wa;
  logic [7:0]            last_wd;
  logic                  b_stb;
  logic [5:0]            b_wa;
  logic [7:0]            b_wd;
  logic [5:0]            b_ra;
  logic [7:0]            b_cnt;
  logic [7:0]            b_seen;
  int                    errors;
  int                    total_checks;
  dhrap_if bus_a ();
  dhrap_if bus_b ();
  dhrap_dev u_dhrap_dev (.SYS_CLK_I(sys_clk), .NRST_I(nrst), .bus(bus_a), .WR_STB_O(wr_stb),
    .WR_ADDR_O(wr_addr), .WR_DATA_O(wr_data), .RD_ADDR_O(rd_addr), .RD_DATA_I(regs[rd_addr]));
  dhrap_host #(.HALF(4), .PSTB(8)) u_dhrap_host (.SYS_CLK_I(sys_clk), .NRST_I(nrst), .bus(bus_a),
    .REQ_I(req), .CMD_I(cmd), .ADDR_I(addr), .DATA_I(data), .BUSY_O(busy), .DONE_O(done),
    .RDATA_O(rdata));
  // Second device; its read side returns a value built from the address so reads differ.
  dhrap_dev u_dhrap_dev2 (.SYS_CLK_I(sys_clk), .NRST_I(nrst), .bus(bus_b), .WR_STB_O(b_stb),
    .WR_ADDR_O(b_wa), .WR_DATA_O(b_wd), .RD_ADDR_O(b_ra), .RD_DATA_I({2'b10, b_ra}));
  dhrap_props u_props (.SYS_CLK_I(sys_clk), .NRST_I(nrst), .scl(bus_a.scl), .sda(bus_a.sda),
    .sda_dev_o(bus_a.sda_dev_o), .sda_dev_oe(bus_a.sda_dev_oe),
    .host_shared_bus_dev_oe(bus_a.host_shared_bus_dev_oe),
    .host_write_strobe_n(bus_a.host_write_strobe_n),
    .host_read_strobe_n(bus_a.host_read_strobe_n), .chip_sel_n(bus_a.chip_sel_n));
  // ------------------------------------------------------------------
  // Clock, register space and write monitors
  // ------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Each write pulse of the first device lands in the register model and is counted; the second device's pulses are only counted.
  always @(posedge sys_clk) begin
    if (wr_stb === 1'b1) begin
      regs[wr_addr] <= wr_data;
      wr_cnt        <= wr_cnt + 8'h01;
      last_wa       <= {2'b00, wr_addr};
      last_wd       <= wr_data;
    end
    if (b_stb === 1'b1) begin
      b_cnt <= b_cnt + 8'h01;
    end
  end
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One host command; waits on the done pulse under a bound.
  task automatic host_op(input dhrap_pkg::dhrap_cmd_t c, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] r);
    int n;
    @(posedge sys_clk);
    req  <= 1'b1;
    cmd  <= c;
    addr <= a;
    data <= d;
    @(posedge sys_clk);
    req <= 1'b0;
    @(negedge sys_clk);
    check({7'h00, busy}, 8'h01);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (done !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      errors++;
      stop_test();
    end
    r = rdata;
    repeat (6) @(posedge sys_clk);
  endtask
  // Address phase on the second bus.
  task automatic b_latch(input logic [7:0] a);
    @(posedge sys_clk);
    bus_b.host_shared_bus_host_o  <= a;
    bus_b.host_shared_bus_host_oe <= 1'b1;
    bus_b.ale                     <= 1'b1;
    repeat (4) @(posedge sys_clk);
    bus_b.ale <= 1'b0;
    repeat (4) @(posedge sys_clk);
    bus_b.host_shared_bus_host_oe <= 1'b0;
  endtask
  // One strobe of eight cycles; the bus is sampled just before the strobe rises.
  task automatic b_access(input logic wr, input logic csn, input logic [7:0] d);
    @(posedge sys_clk);
    bus_b.chip_sel_n              <= csn;
    bus_b.host_shared_bus_host_o  <= d;
    bus_b.host_shared_bus_host_oe <= wr;
    repeat (2) @(posedge sys_clk);
    if (wr) bus_b.host_write_strobe_n <= 1'b0;
    else bus_b.host_read_strobe_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    b_seen = bus_b.host_shared_bus;
    bus_b.host_write_strobe_n <= 1'b1;
    bus_b.host_read_strobe_n  <= 1'b1;
    repeat (4) @(posedge sys_clk);
    bus_b.chip_sel_n              <= 1'b1;
    bus_b.host_shared_bus_host_oe <= 1'b0;
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_serial;
    logic [7:0] r;
    logic [7:0] n0;
    n0 = wr_cnt;
    host_op(dhrap_pkg::DHRAP_CMD_SER_WR, 8'h12, 8'hA5, r);
    check(wr_cnt - n0, 8'h01);
    check(last_wa, 8'h12);
    check(last_wd, 8'hA5);
    host_op(dhrap_pkg::DHRAP_CMD_SER_RD, 8'h12, 8'h00, r);
    check(r, 8'hA5);
    host_op(dhrap_pkg::DHRAP_CMD_SER_WR, 8'h40, 8'h00, r);
    check(last_wa, 8'h00);
    check(last_wd, 8'h00);
  endtask
  // Parallel write with upper address bits set, then reads across both routes.
  task automatic t_parallel;
    logic [7:0] r;
    logic [7:0] n0;
    n0 = wr_cnt;
    host_op(dhrap_pkg::DHRAP_CMD_PAR_WR, 8'h47, 8'h3C, r);
    check(wr_cnt - n0, 8'h01);
    check(last_wa, 8'h07);
    check(last_wd, 8'h3C);
    host_op(dhrap_pkg::DHRAP_CMD_PAR_RD, 8'h12, 8'h00, r);
    check(r, 8'hA5);
    host_op(dhrap_pkg::DHRAP_CMD_SER_RD, 8'h07, 8'h00, r);
    check(r, 8'h3C);
    host_op(dhrap_pkg::DHRAP_CMD_PAR_RD, 8'hC7, 8'h00, r);
    check(r, 8'h3C);
  endtask
  // Strobes without chip select first, then the same accesses selected.
  task automatic t_chip_select;
    b_latch(8'h45);
    b_access(1'b1, 1'b1, 8'h99);
    check(b_cnt, 8'h00);
    b_access(1'b0, 1'b1, 8'h00);
    check(b_seen, 8'hFF);
    b_access(1'b1, 1'b0, 8'h99);
    check(b_cnt, 8'h01);
    check({2'b00, b_wa}, 8'h05);
    check(b_wd, 8'h99);
    b_access(1'b0, 1'b0, 8'h00);
    check(b_seen, 8'h85);
    check(bus_b.host_shared_bus, 8'hFF);
  endtask
  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    foreach (regs[i]) regs[i] = 8'h00;
    {errors, total_checks} = '0;
    {nrst, req, addr, data, wr_cnt, b_cnt} = '0;
    cmd = dhrap_pkg::DHRAP_CMD_SER_WR;
    {bus_b.scl, bus_b.sda_host_o, bus_b.sda_host_oe, bus_b.ale} = 4'b1100;
    {bus_b.host_write_strobe_n, bus_b.host_read_strobe_n, bus_b.chip_sel_n} = 3'b111;
    bus_b.host_shared_bus_host_o  = 8'h00;
    bus_b.host_shared_bus_host_oe = 1'b0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_serial();
    t_parallel();
    t_chip_select();
    stop_test();
  end
  // All scenarios take a few thousand cycles; this margin catches a hang.
  initial begin
    repeat (40000) @(posedge sys_clk);
    errors++;
    stop_test();
  end
endmodule

// ===== verilog/dhrap_dev.sv
// Device end: serial slave and multiplexed parallel port onto one register space.
`timescale 1ns/1ps
module dhrap_dev (
  input  wire logic       SYS_CLK_I,
  input  wire logic       NRST_I,
  dhrap_if.dev            bus,
  output logic            WR_STB_O,
  output logic [5:0]      WR_ADDR_O,
  output logic [7:0]      WR_DATA_O,
  output logic [5:0]      RD_ADDR_O,
  input  wire logic [7:0] RD_DATA_I
);
  typedef enum {S_IDLE, S_ADDR, S_ACK, S_RADDR, S_WDATA, S_SEND, S_RACK, S_DONE} dhrap_sst_t;

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic [1:0] scl_s, sda_s, ale_s, wr_s, rd_s, cs_s;
  logic [7:0] bus_s1, bus_s2;
  logic       scl_d, sda_d, ale_d, wr_d;
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      scl_s  <= 2'h3;
      sda_s  <= 2'h3;
      ale_s  <= 2'h0;
      wr_s   <= 2'h3;
      rd_s   <= 2'h3;
      cs_s   <= 2'h3;
      bus_s1 <= 8'hFF;
      bus_s2 <= 8'hFF;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
      ale_d  <= 1'b0;
      wr_d   <= 1'b1;
    end else begin
      scl_s  <= {scl_s[0], bus.scl};
      sda_s  <= {sda_s[0], bus.sda};
      ale_s  <= {ale_s[0], bus.ale};
      wr_s   <= {wr_s[0], bus.host_write_strobe_n};
      rd_s   <= {rd_s[0], bus.host_read_strobe_n};
      cs_s   <= {cs_s[0], bus.chip_sel_n};
      bus_s1 <= bus.host_shared_bus;
      bus_s2 <= bus_s1;
      scl_d  <= scl_s[1];
      sda_d  <= sda_s[1];
      ale_d  <= ale_s[1];
      wr_d   <= wr_s[1];
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s[1] & ~scl_d;
  assign scl_fall = ~scl_s[1] & scl_d;
  assign start_c  = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  assign stop_c   = scl_s[1] & scl_d & ~sda_d & sda_s[1];

  // ------------------------------------------------------------------
  // Serial slave
  // ------------------------------------------------------------------
  dhrap_sst_t sst, next_sst, ret, next_ret;
  logic [7:0] shreg, next_shreg;
  logic [2:0] bitc, next_bitc;
  logic [5:0] ser_addr, next_ser_addr;
  logic       sda_low, next_sda_low;
  logic       ser_wr, next_ser_wr;
  logic [7:0] ser_wdata, next_ser_wdata;
  logic       full, next_full;
  always_comb begin
    next_sst       = sst;
    next_ret       = ret;
    next_shreg     = shreg;
    next_bitc      = bitc;
    next_ser_addr  = ser_addr;
    next_sda_low   = sda_low;
    next_ser_wr    = 1'b0;
    next_ser_wdata = ser_wdata;
    next_full      = full;
    if (start_c) begin
      next_sst     = S_ADDR;
      next_bitc    = 3'h0;
      next_full    = 1'b0;
      next_sda_low = 1'b0;
    end else if (stop_c) begin
      next_sst     = S_IDLE;
      next_sda_low = 1'b0;
    end else begin
      case (sst)
        S_ADDR, S_RADDR, S_WDATA: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s[1]};
            next_bitc  = bitc + 3'h1;
            next_full  = (bitc == 3'h7);
          end
          if (scl_fall && full) begin
            next_full = 1'b0;
            next_sst  = S_IDLE;
            if (sst == S_ADDR && shreg == dhrap_pkg::SER_WRITE_ADDR) begin
              next_ret = S_RADDR;
              next_sst = S_ACK;
            end else if (sst == S_ADDR && shreg == dhrap_pkg::SER_READ_ADDR) begin
              next_shreg = RD_DATA_I;
              next_ret   = S_SEND;
              next_sst   = S_ACK;
            end else if (sst == S_RADDR) begin
              next_ser_addr = shreg[5:0] & dhrap_pkg::ADDR_MASK;
              next_ret      = S_WDATA;
              next_sst      = S_ACK;
            end else if (sst == S_WDATA) begin
              next_ser_wr    = 1'b1;
              next_ser_wdata = shreg;
              next_ret       = S_DONE;
              next_sst       = S_ACK;
            end
            next_sda_low = (next_sst == S_ACK);
            next_shreg   = (next_ret == S_SEND) ? RD_DATA_I : 8'h00;
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            next_sst     = ret;
            next_sda_low = (ret == S_SEND) ? ~shreg[7] : 1'b0;
            next_bitc    = 3'h0;
            if (ret != S_SEND) next_shreg = 8'h00;
          end
        end
        S_SEND: begin
          if (scl_fall) begin
            next_bitc    = bitc + 3'h1;
            next_shreg   = {shreg[6:0], 1'b0};
            next_sda_low = (bitc == 3'h7) ? 1'b0 : ~shreg[6];
            if (bitc == 3'h7) next_sst = S_RACK;
          end
        end
        S_RACK:  if (scl_fall) next_sst = S_DONE;
        S_DONE:  next_sda_low = 1'b0;
        S_IDLE:  next_sda_low = 1'b0;
        default: next_sst = S_IDLE;
      endcase
    end
  end
  // A flag marks a whole byte after the eighth rising clock, so a byte of all
  // zeros is taken like any other.
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      sst       <= S_IDLE;
      ret       <= S_IDLE;
      shreg     <= 8'h00;
      bitc      <= 3'h0;
      ser_addr  <= 6'h00;
      sda_low   <= 1'b0;
      ser_wr    <= 1'b0;
      ser_wdata <= 8'h00;
      full      <= 1'b0;
    end else begin
      sst       <= next_sst;
      ret       <= next_ret;
      shreg     <= next_shreg;
      bitc      <= next_bitc;
      ser_addr  <= next_ser_addr;
      sda_low   <= next_sda_low;
      ser_wr    <= next_ser_wr;
      ser_wdata <= next_ser_wdata;
      full      <= next_full;
    end
  end

  // ------------------------------------------------------------------
  // Parallel port
  // ------------------------------------------------------------------
  logic [5:0] par_addr, next_par_addr;
  logic       par_wr, next_par_wr;
  logic [7:0] par_wdata, next_par_wdata;
  logic       drive, next_drive;
  logic [7:0] rdata, next_rdata;
  always_comb begin
    next_par_addr  = par_addr;
    next_par_wr    = 1'b0;
    next_par_wdata = par_wdata;
    if (ale_d && !ale_s[1]) next_par_addr = bus_s2[5:0] & dhrap_pkg::ADDR_MASK;
    if (wr_d && !wr_s[1] && !cs_s[1]) begin
      next_par_wr    = 1'b1;
      next_par_wdata = bus_s2;
    end
    next_drive = !rd_s[1] && !cs_s[1];
    next_rdata = RD_DATA_I;
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      par_addr  <= 6'h00;
      par_wr    <= 1'b0;
      par_wdata <= 8'h00;
      drive     <= 1'b0;
      rdata     <= 8'h00;
    end else begin
      par_addr  <= next_par_addr;
      par_wr    <= next_par_wr;
      par_wdata <= next_par_wdata;
      drive     <= next_drive;
      rdata     <= next_rdata;
    end
  end

  // ------------------------------------------------------------------
  // Merge onto the register space
  // ------------------------------------------------------------------
  // shared register space; read path separate from write path.
  // Parallel writes take priority if both routes strike in one cycle.
  logic       wstb, next_wstb;
  logic [5:0] waddr, next_waddr, raddr, next_raddr;
  logic [7:0] wdata, next_wdata;
  always_comb begin
    next_wstb  = par_wr | ser_wr;
    next_waddr = par_wr ? par_addr : (ser_wr ? ser_addr : waddr);
    next_wdata = par_wr ? par_wdata : (ser_wr ? ser_wdata : wdata);
    next_raddr = (sst == S_IDLE || sst == S_DONE) ? par_addr : ser_addr;
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      wstb  <= 1'b0;
      waddr <= 6'h00;
      wdata <= 8'h00;
      raddr <= 6'h00;
    end else begin
      wstb  <= next_wstb;
      waddr <= next_waddr;
      wdata <= next_wdata;
      raddr <= next_raddr;
    end
  end

  assign WR_STB_O   = wstb;
  assign WR_ADDR_O  = waddr;
  assign WR_DATA_O  = wdata;
  assign RD_ADDR_O  = raddr;
  assign bus.sda_dev_o  = 1'b0;
  assign bus.sda_dev_oe = sda_low;
  assign bus.host_shared_bus_dev_o  = rdata;
  assign bus.host_shared_bus_dev_oe = drive;
endmodule

// ===== verilog/dhrap_host.sv
// Host end: issues single-byte serial or parallel register accesses.
`timescale 1ns/1ps
module dhrap_host #(
  parameter int HALF = dhrap_pkg::SCL_HALF_CYC,
  parameter int PSTB = dhrap_pkg::PAR_STROBE_CYC
) (
  input  wire logic                 SYS_CLK_I,
  input  wire logic                 NRST_I,
  dhrap_if.host                     bus,
  input  wire logic                 REQ_I,
  input  wire dhrap_pkg::dhrap_cmd_t CMD_I,
  input  wire logic [7:0]           ADDR_I,
  input  wire logic [7:0]           DATA_I,
  output logic                      BUSY_O,
  output logic                      DONE_O,
  output logic [7:0]                RDATA_O
);
  typedef enum {H_IDLE, H_PHASE} dhrap_hst_t;
  // Two start steps, 27 slots of three steps, then three stop steps.
  localparam int QN = 89;

  // ------------------------------------------------------------------
  // Sequencer: a list of steps, three to a serial bit, played at a fixed pace
  // ------------------------------------------------------------------
  dhrap_hst_t st, next_st;
  logic [15:0] tmr, next_tmr;
  logic [6:0]  step, next_step;
  logic        scl, next_scl, sda, next_sda, ale, next_ale, wrn, next_wrn, rdn, next_rdn;
  logic        csn, next_csn, boe, next_boe, done, next_done;
  logic [7:0]  bo, next_bo, rdat, next_rdat;
  dhrap_pkg::dhrap_cmd_t cmd, next_cmd;
  logic [7:0]  a, next_a, d, next_d;
  logic        pass2, next_pass2;
  logic        par;
  assign par = (cmd == dhrap_pkg::DHRAP_CMD_PAR_WR) || (cmd == dhrap_pkg::DHRAP_CMD_PAR_RD);

  // Serial bit for a given byte slot: 9 slots per byte, slot 8 is acknowledge.
  function automatic logic ser_bit(input logic [7:0] b, input logic [3:0] k);
    ser_bit = (k > 4'h7) ? 1'b1 : b[3'h7 - k[2:0]];
  endfunction

  always_comb begin
    logic [3:0] k;
    logic [6:0] slot;
    k = 4'h0;
    slot = 7'h00;
    next_st = st; next_tmr = tmr; next_step = step; next_scl = scl; next_sda = sda;
    next_ale = ale; next_wrn = wrn; next_rdn = rdn; next_csn = csn; next_boe = boe;
    next_bo = bo; next_rdat = rdat; next_cmd = cmd; next_a = a; next_d = d;
    next_pass2 = pass2;
    next_done = 1'b0;
    case (st)
      H_IDLE: begin
        if (REQ_I) begin
          next_st = H_PHASE; next_cmd = CMD_I; next_a = ADDR_I; next_d = DATA_I;
          next_step = 7'h00; next_tmr = 16'h0000;
          next_pass2 = 1'b0;
        end
      end
      H_PHASE: begin
        next_tmr = tmr + 16'h0001;
        if (tmr >= 16'(par ? PSTB : HALF)) begin
          next_tmr  = 16'h0000;
          next_step = step + 7'h01;
          if (par) begin
            case (step)
              7'h00: begin next_boe = 1'b1; next_bo = a; next_ale = 1'b1; end
              7'h01: next_ale = 1'b0;
              7'h02: begin
                next_csn = 1'b0;
                next_boe = (cmd == dhrap_pkg::DHRAP_CMD_PAR_WR);
                next_bo  = d;
              end
              7'h03: if (cmd == dhrap_pkg::DHRAP_CMD_PAR_WR) next_wrn = 1'b0;
                     else next_rdn = 1'b0;
              7'h04: begin next_rdat = bus.host_shared_bus; next_wrn = 1'b1; next_rdn = 1'b1; end
              7'h05: begin next_csn = 1'b1; next_boe = 1'b0; end
              default: begin next_st = H_IDLE; next_done = 1'b1; end
            endcase
          end else begin
            // Each bit: low-data, clock high, clock low. Frame = start + 3 bytes + stop for a write, 2 bytes per read pass.
            slot = step / 7'd3;
            k    = 4'(slot % 7'd9);
            if (step == 7'h00) next_sda = 1'b0;
            else if (step == 7'h01) next_scl = 1'b0;
            else if (step >= 7'h02 && step < 7'(QN - 6)) begin
              slot = (step - 7'h02) / 7'd3;
              k    = 4'(slot % 7'd9);
              case ((step - 7'h02) % 7'd3)
                7'h0: begin
                  // second byte; the second pass frees the line for the device's data.
                  if (pass2 && slot >= 7'd9 && slot < 7'd18)
                    next_sda = 1'b1;
                  else if (slot < 7'd9)
                    next_sda = ser_bit(pass2 ?
                                       dhrap_pkg::SER_READ_ADDR : dhrap_pkg::SER_WRITE_ADDR, k);
                  else if (slot < 7'd18) next_sda = ser_bit(a, k);
                  else next_sda = ser_bit(d, k);
                end
                7'h1: begin
                  next_scl = 1'b1;
                  if (pass2 && slot >= 7'd9 && k < 4'h8)
                    next_rdat = {rdat[6:0], bus.sda};
                end
                default: next_scl = 1'b0;
              endcase
              // each read pass is two bytes long.
              if (cmd == dhrap_pkg::DHRAP_CMD_SER_RD && slot >= 7'd18) next_step = 7'(QN - 6);
            end else if (step == 7'(QN - 6)) next_sda = 1'b0;
            else if (step == 7'(QN - 5)) next_scl = 1'b1;
            else if (step == 7'(QN - 4)) next_sda = 1'b1;
            // address pass and STOP, then a new START with 3FH.
            else if (cmd == dhrap_pkg::DHRAP_CMD_SER_RD && !pass2) begin
              next_pass2 = 1'b1;
              next_step  = 7'h00;
            end
            else begin next_st = H_IDLE; next_done = 1'b1; end
          end
        end
      end
      default: next_st = H_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      st <= H_IDLE; tmr <= 16'h0000; step <= 7'h00; scl <= 1'b1; sda <= 1'b1;
      ale <= 1'b0; wrn <= 1'b1; rdn <= 1'b1; csn <= 1'b1; boe <= 1'b0;
      bo <= 8'h00; rdat <= 8'h00; done <= 1'b0;
      cmd <= dhrap_pkg::DHRAP_CMD_SER_WR; a <= 8'h00; d <= 8'h00;
      pass2 <= 1'b0;
    end else begin
      st <= next_st; tmr <= next_tmr; step <= next_step; scl <= next_scl; sda <= next_sda;
      ale <= next_ale; wrn <= next_wrn; rdn <= next_rdn; csn <= next_csn; boe <= next_boe;
      bo <= next_bo; rdat <= next_rdat; done <= next_done;
      cmd <= next_cmd; a <= next_a; d <= next_d;
      pass2 <= next_pass2;
    end
  end

  logic busy;
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) busy <= 1'b0;
    else busy <= (next_st != H_IDLE);
  end
  assign BUSY_O  = busy;
  assign DONE_O  = done;
  assign RDATA_O = rdat;
  assign bus.scl = scl;
  assign bus.sda_host_o  = 1'b0;
  assign bus.sda_host_oe = ~sda;
  assign bus.host_shared_bus_host_o  = bo;
  assign bus.host_shared_bus_host_oe = boe;
  assign bus.ale = ale;
  assign bus.host_write_strobe_n = wrn;
  assign bus.host_read_strobe_n  = rdn;
  assign bus.chip_sel_n = csn;
endmodule

// ===== verilog/dhrap_if.sv
// Interface joining the register port device and its host.
`timescale 1ns/1ps
interface dhrap_if;
  logic       scl;
  logic       sda_dev_o;
  logic       sda_dev_oe;
  logic       sda_host_o;
  logic       sda_host_oe;
  logic       sda;
  logic [7:0] host_shared_bus_dev_o;
  logic       host_shared_bus_dev_oe;
  logic [7:0] host_shared_bus_host_o;
  logic       host_shared_bus_host_oe;
  logic [7:0] host_shared_bus;
  logic       ale;
  logic       host_write_strobe_n;
  logic       host_read_strobe_n;
  logic       chip_sel_n;

  // ------------------------------------------------------------------
  // Wire resolution
  // ------------------------------------------------------------------
  // Open-drain line: either end pulling low wins.
  assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_host_oe & ~sda_host_o));
  // Bus level; idle bus reads as all ones like a pulled-up line.
  assign host_shared_bus = host_shared_bus_dev_oe  ? host_shared_bus_dev_o :
                           host_shared_bus_host_oe ? host_shared_bus_host_o : 8'hFF;

  modport dev (
    input  scl, sda, host_shared_bus, ale, host_write_strobe_n, host_read_strobe_n,
    input  chip_sel_n,
    output sda_dev_o, sda_dev_oe, host_shared_bus_dev_o, host_shared_bus_dev_oe
  );
  modport host (
    input  sda, host_shared_bus,
    output scl, sda_host_o, sda_host_oe, host_shared_bus_host_o, host_shared_bus_host_oe,
    output ale, host_write_strobe_n, host_read_strobe_n, chip_sel_n
  );
endinterface

// ===== verilog/dhrap_pkg.sv
// Shared constants and types for the dual host register access port.
package dhrap_pkg;
  // ------------------------------------------------------------------
  // Serial bus addresses and widths
  // ------------------------------------------------------------------
  localparam logic [7:0] SER_WRITE_ADDR = 8'h3E;
  localparam logic [7:0] SER_READ_ADDR  = 8'h3F;
  localparam int         DATA_W         = 8;
  localparam int         REG_ADDR_W     = 6;
  localparam logic [5:0] ADDR_MASK      = 6'h3F;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SCL_HALF_NS    = 2500;
  localparam int SCL_HALF_CYC   = SCL_HALF_NS / CLK_PERIOD_NS;
  localparam int PAR_STROBE_NS  = 200;
  localparam int PAR_STROBE_CYC = (PAR_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ------------------------------------------------------------------
  // Host command codes
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    DHRAP_CMD_SER_WR,
    DHRAP_CMD_SER_RD,
    DHRAP_CMD_PAR_WR,
    DHRAP_CMD_PAR_RD
  } dhrap_cmd_t;
endpackage
